// ==== include/cpmc_pkg.sv ====
// Constants, register map and carrier types of the pump mode control
//==============================================================
//==============================================================
package cpmc_pkg;

    //==========================================================
    // Clock and timing
    localparam int CLK_HZ        = 125_000_000; // System clock rate
    localparam int CLK_PER_US    = CLK_HZ / 1_000_000;
    localparam int SHORT_DEB_US  = 240;         // Normal debounce
    localparam int LONG_DEB_US   = 2000;        // First debounce, long
    localparam int SHORT_DEB_CYC = SHORT_DEB_US * CLK_PER_US;
    localparam int LONG_DEB_CYC  = LONG_DEB_US * CLK_PER_US;
    localparam int DEB_W         = 18;          // Holds LONG_DEB_CYC
    localparam int FAST_PUMP_HZ  = 1_000_000;   // Select bit 0
    localparam int SLOW_PUMP_HZ  = 500_000;     // Select bit 1
    localparam int FAST_PUMP_CYC = CLK_HZ / FAST_PUMP_HZ;
    localparam int SLOW_PUMP_CYC = CLK_HZ / SLOW_PUMP_HZ;
    localparam int DIV_W         = 8;           // Holds SLOW_PUMP_CYC

    //==========================================================
    // Register map, at the printed offsets on the byte bus
    localparam logic [7:0] ADDR_CTRL   = 8'h18; // pump_control
    localparam logic [7:0] ADDR_LINK   = 8'h36; // pump_sink_link
    localparam logic [7:0] ADDR_STATUS = 8'h37; // sink_low_voltage_status
    localparam logic [7:0] CTRL_RST    = 8'h80; // Self-start set
    localparam logic [4:0] LINK_RST    = 5'h00;
    localparam int         NUM_SINKS   = 5;
    localparam logic [1:0] RATIO_BYPASS = 2'h0; // Read value for 1:1
    localparam logic [1:0] RATIO_DOUBLE = 2'h2; // Read value for 1:2

    //==========================================================
    // Control register layout, bit 7 down to bit 0
    typedef struct packed {
        logic       pump_self_start;     // Bit 7
        logic       long_first_debounce; // Bit 6
        logic       pulldown_off;        // Bit 5
        logic       pump_clock_select;   // Bit 4
        logic       ratio_algorithm_select; // Bit 3
        logic [1:0] pump_ratio_field;    // Bits 2:1
        logic       pump_enable_bit;     // Bit 0
    } cpmc_ctrl_t;

    // Register port from software
    typedef struct packed {
        logic [7:0] addr;  // Register offset
        logic [7:0] wdata; // Write data
        logic       wr;    // Write strobe
        logic       rd;    // Read strobe
    } cpmc_bus_t;

    // Commands to the analog pump
    typedef struct packed {
        logic on;           // Pump running
        logic ratio_double; // 1 selects 1:2, 0 bypass
        logic clk_en;       // One-cycle pump clock pulse
    } cpmc_pump_t;

endpackage

// ==== hw/cpmc_clkdiv.sv ====
// Pump switching clock divider giving one-cycle enable pulses
`timescale 1ns/1ns
`default_nettype none
module cpmc_clkdiv
    import cpmc_pkg::*;
(
    input  wire logic i_clk,    // System clock
    input  wire logic i_sys_rst, // Synchronous reset
    input  wire logic i_run,    // Pump running
    input  wire logic i_slow,   // 1 selects 500 kHz
    output logic      o_en      // Pump clock pulse
);
    //==========================================================
    // State
    typedef struct packed {
        logic [DIV_W-1:0] cnt; // Cycles since last pulse
        logic             en;  // Registered pulse
    } cpmc_div_t;

    cpmc_div_t        s_q;
    cpmc_div_t        s_d;
    logic [DIV_W-1:0] last; // Final count of the period

    // Period end; >= keeps a mid-period select change safe
    always_comb begin
        s_d  = s_q;
        last = i_slow ? DIV_W'(SLOW_PUMP_CYC - 1)
                      : DIV_W'(FAST_PUMP_CYC - 1);
        s_d.en = 1'b0;
        if (!i_run) begin
            s_d.cnt = '0;
        end else if (s_q.cnt >= last) begin
            s_d.cnt = '0;
            s_d.en  = 1'b1;
        end else begin
            s_d.cnt = s_q.cnt + 1'b1;
        end
    end

    // Register
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign o_en = s_q.en;

    property p_pulse_period;
        @(posedge i_clk) disable iff (i_sys_rst)
        (i_run && !i_slow && s_q.cnt == DIV_W'(FAST_PUMP_CYC - 1))
            |=> o_en;
    endproperty
    a_pulse_period: assert property (p_pulse_period)
        else $error("pump clock pulse missing at 1 MHz period");
endmodule
`default_nettype wire

// ==== hw/cpmc_debounce.sv ====
// Debounce timer for the linked-sink low-voltage condition
`timescale 1ns/1ns
`default_nettype none
module cpmc_debounce
    import cpmc_pkg::*;
#(
    parameter int SHORT_CYC = SHORT_DEB_CYC, // Normal length
    parameter int LONG_CYC  = LONG_DEB_CYC   // First, long length
) (
    input  wire logic i_clk,     // System clock
    input  wire logic i_sys_rst, // Synchronous reset
    input  wire logic i_run,     // Condition present
    input  wire logic i_long,    // Use the long length
    output logic      o_done     // Condition held long enough
);
    //==========================================================
    // State
    typedef struct packed {
        logic [DEB_W-1:0] cnt; // Cycles the condition held
    } cpmc_deb_t;

    cpmc_deb_t        s_q;
    cpmc_deb_t        s_d;
    logic [DEB_W-1:0] last; // Final count

    // Count while held, restart from zero when it drops
    always_comb begin
        s_d  = s_q;
        last = i_long ? DEB_W'(LONG_CYC - 1)
                      : DEB_W'(SHORT_CYC - 1);
        o_done = i_run && (s_q.cnt >= last);
        if (!i_run || o_done) begin
            s_d.cnt = '0;
        end else begin
            s_d.cnt = s_q.cnt + 1'b1;
        end
    end

    // Register
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    property p_restart;
        @(posedge i_clk) disable iff (i_sys_rst)
        !i_run |=> s_q.cnt == '0;
    endproperty
    a_restart: assert property (p_restart)
        else $error("debounce did not restart");

    property p_done_len;
        @(posedge i_clk) disable iff (i_sys_rst)
        (o_done && !i_long) |-> s_q.cnt == DEB_W'(SHORT_CYC - 1);
    endproperty
    a_done_len: assert property (p_done_len)
        else $error("short debounce ended at wrong count");
endmodule
`default_nettype wire

// ==== hw/cpmc_top.sv ====
// Charge pump ratio control with its register file
`timescale 1ns/1ns
`default_nettype none
module cpmc_top #(
    parameter int SHORT_CYC = cpmc_pkg::SHORT_DEB_CYC, // 240 us
    parameter int LONG_CYC  = cpmc_pkg::LONG_DEB_CYC   // 2 ms
) (
    input  wire logic               i_clk,      // 125 MHz
    input  wire logic               i_sys_rst,  // Sync, high
    input  wire cpmc_pkg::cpmc_bus_t i_bus,     // Register port
    output logic [7:0]              o_rdata,    // Read data
    input  wire logic [4:0]         i_sink_low, // Comparator flags
    input  wire logic [4:0]         i_sink_on,  // Sinks enabled
    output cpmc_pkg::cpmc_pump_t    o_pump,     // Pump commands
    output logic                    o_onkey_pulldown_en // Key pull
);
    import cpmc_pkg::*;

    //==========================================================
    // Decoding helpers

    // Ratio field upper bit picks the doubler; 00 and 01 are bypass
    function automatic logic ratio_is_double(input logic [1:0] f);
        ratio_is_double = f[1];
    endfunction

    //==========================================================
    // State of the block, held as one record
    typedef struct packed {
        cpmc_ctrl_t ctrl;       // pump_control contents
        logic [4:0] link;       // pump_sink_link bits
        logic       doubled;    // Automatic ratio latched at 1:2
        logic       first_done; // First debounce since start over
        logic       started;    // Self-start has fired
        logic [7:0] rdata;      // Read answer
    } cpmc_state_t;

    cpmc_state_t s_q; // Registered state
    cpmc_state_t s_d; // Next state

    //==========================================================
    // Combinational terms
    logic [4:0] linked_low; // Low flags of linked sinks only
    logic       low_any;    // Some linked sink is low
    logic       self_hit;   // Linked, enabled and low
    logic       active;     // Pump running
    logic       auto_mode;  // Automatic ratio selection
    logic       deb_run;    // Debounce condition present
    logic       deb_long;   // Use the long first debounce
    logic       deb_done;   // Debounce elapsed
    logic       ratio_now;  // Ratio actually applied, 1 is 1:2
    logic [1:0] ratio_read; // Ratio field as software reads it
    logic       clk_en;     // Pump clock pulse

    // Sink masking, pump activity and mode selection
    always_comb begin
        // Unlinked sinks are dropped here and never reach timing
        linked_low = i_sink_low & s_q.link;
        low_any    = |linked_low;
        self_hit   = |(linked_low & i_sink_on);
        // Pump bit, or self-start once it has fired
        active     = s_q.ctrl.pump_enable_bit
                   || (s_q.ctrl.pump_self_start && s_q.started);
        auto_mode  = !s_q.ctrl.ratio_algorithm_select;
        // Timer only runs while a switch-up is still possible
        deb_run    = active && auto_mode && !s_q.doubled
                   && low_any;
        // Long length only for the first debounce after start
        deb_long   = s_q.ctrl.long_first_debounce
                   && !s_q.first_done;
    end

    // Applied ratio: off is bypass, manual follows the field
    always_comb begin
        if (!active) begin
            ratio_now = 1'b0;
        end else if (!auto_mode) begin
            ratio_now = ratio_is_double(
                            s_q.ctrl.pump_ratio_field);
        end else begin
            ratio_now = s_q.doubled;
        end
        // Automatic mode reports what is really in use
        if (auto_mode) begin
            ratio_read = ratio_now ? RATIO_DOUBLE
                                   : RATIO_BYPASS;
        end else begin
            ratio_read = s_q.ctrl.pump_ratio_field;
        end
    end

    //==========================================================
    // Debounce timer
    cpmc_debounce #(
        .SHORT_CYC (SHORT_CYC),
        .LONG_CYC  (LONG_CYC)
    ) u_deb (
        .i_clk     (i_clk),
        .i_sys_rst (i_sys_rst),
        .i_run     (deb_run),
        .i_long    (deb_long),
        .o_done    (deb_done)
    );

    //==========================================================
    // Pump switching clock
    cpmc_clkdiv u_div (
        .i_clk     (i_clk),
        .i_sys_rst (i_sys_rst),
        .i_run     (active),
        .i_slow    (s_q.ctrl.pump_clock_select),
        .o_en      (clk_en)
    );

    //==========================================================
    // Next state
    always_comb begin
        s_d       = s_q;
        s_d.rdata = 8'h00; // Read data stand for one cycle only

        // Register writes; unmapped offsets are ignored
        if (i_bus.wr) begin
            unique case (i_bus.addr)
                ADDR_CTRL: begin
                    s_d.ctrl = cpmc_ctrl_t'(i_bus.wdata);
                end
                ADDR_LINK: begin
                    s_d.link = i_bus.wdata[4:0];
                end
                default: begin
                    // Status is read-only, others unmapped
                end
            endcase
        end

        // Register reads; unmapped offsets answer zero
        if (i_bus.rd) begin
            unique case (i_bus.addr)
                ADDR_CTRL: begin
                    s_d.rdata = {s_q.ctrl[7:3], ratio_read,
                                 s_q.ctrl.pump_enable_bit};
                end
                ADDR_LINK: begin
                    s_d.rdata = {3'h0, s_q.link};
                end
                ADDR_STATUS: begin
                    // Live comparator flags, all five sinks
                    s_d.rdata = {3'h0, i_sink_low};
                end
                default: begin
                    s_d.rdata = 8'h00;
                end
            endcase
        end

        // Self-start latch; dropping the bit hands control back
        if (!s_q.ctrl.pump_self_start) begin
            s_d.started = 1'b0;
        end else if (self_hit) begin
            s_d.started = 1'b1;
        end

        // Ratio latch: only a completed debounce sets it
        if (!active) begin
            // Off returns to bypass and rearms the long debounce
            s_d.doubled    = 1'b0;
            s_d.first_done = 1'b0;
        end else if (deb_done) begin
            s_d.doubled    = 1'b1;
            s_d.first_done = 1'b1;
        end
        // No branch clears doubled while running: no way back
    end

    //==========================================================
    // State register
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            s_q.ctrl       <= cpmc_ctrl_t'(CTRL_RST);
            s_q.link       <= LINK_RST;
            s_q.doubled    <= 1'b0;
            s_q.first_done <= 1'b0;
            s_q.started    <= 1'b0;
            s_q.rdata      <= 8'h00;
        end else begin
            s_q <= s_d;
        end
    end

    //==========================================================
    // Outputs
    assign o_rdata             = s_q.rdata;
    assign o_pump.on           = active;
    assign o_pump.ratio_double = ratio_now;
    assign o_pump.clk_en       = clk_en;
    // Pulldown is active low in the control bit
    assign o_onkey_pulldown_en = !s_q.ctrl.pulldown_off;

    // Link bits are meant to be set before the pump bit; a late
    // link simply joins monitoring from then on.

    //==========================================================
    // Checks

    property p_off_bypass;
        @(posedge i_clk) disable iff (i_sys_rst)
        (!s_q.ctrl.pump_enable_bit && !s_q.ctrl.pump_self_start)
            |-> !o_pump.on && !o_pump.ratio_double;
    endproperty
    a_off_bypass: assert property (p_off_bypass)
        else $error("pump not in bypass while off");

    property p_manual;
        @(posedge i_clk) disable iff (i_sys_rst)
        (active && s_q.ctrl.ratio_algorithm_select)
            |-> o_pump.ratio_double == s_q.ctrl.pump_ratio_field[1];
    endproperty
    a_manual: assert property (p_manual)
        else $error("manual ratio not applied");

    property p_no_return;
        @(posedge i_clk) disable iff (i_sys_rst)
        (s_q.doubled && active) |=> s_q.doubled || !$past(active);
    endproperty
    a_no_return: assert property (p_no_return)
        else $error("automatic ratio fell back to bypass");

    property p_unlinked;
        @(posedge i_clk) disable iff (i_sys_rst)
        (!s_q.doubled && (i_sink_low & s_q.link) == 5'h00)
            |=> !s_q.doubled;
    endproperty
    a_unlinked: assert property (p_unlinked)
        else $error("switch-up without a linked low sink");

    property p_start_bypass;
        @(posedge i_clk) disable iff (i_sys_rst)
        $rose(active) |-> !s_q.doubled && !s_q.first_done;
    endproperty
    a_start_bypass: assert property (p_start_bypass)
        else $error("start did not begin in bypass");

    sequence s_switch;
        deb_done && active && auto_mode;
    endsequence
    sequence s_doubled_seen;
        s_q.doubled ##0 o_pump.ratio_double;
    endsequence
    property p_switch_up;
        @(posedge i_clk) disable iff (i_sys_rst)
        s_switch |=> s_doubled_seen or !active;
    endproperty
    a_switch_up: assert property (p_switch_up)
        else $error("debounce done but no switch to 1:2");

    // Checked on release only: before the first edge the state is unknown
    property p_link_reset;
        @(posedge i_clk)
        $fell(i_sys_rst) |-> s_q.link == 5'h00;
    endproperty
    a_link_reset: assert property (p_link_reset)
        else $error("link bits not cleared by reset");

    property p_status;
        @(posedge i_clk) disable iff (i_sys_rst)
        (i_bus.rd && i_bus.addr == ADDR_STATUS)
            |=> o_rdata == {3'h0, $past(i_sink_low)};
    endproperty
    a_status: assert property (p_status)
        else $error("status read wrong");

    property p_self_start;
        @(posedge i_clk) disable iff (i_sys_rst)
        (s_q.ctrl.pump_self_start && self_hit && !i_bus.wr)
            |=> active;
    endproperty
    a_self_start: assert property (p_self_start)
        else $error("self-start did not turn pump on");

    property p_pulldown;
        @(posedge i_clk) disable iff (i_sys_rst)
        (i_bus.wr && i_bus.addr == ADDR_CTRL)
            |=> o_onkey_pulldown_en == !$past(i_bus.wdata[5]);
    endproperty
    a_pulldown: assert property (p_pulldown)
        else $error("pulldown control wrong");

    property p_auto_read;
        @(posedge i_clk) disable iff (i_sys_rst)
        (i_bus.rd && i_bus.addr == ADDR_CTRL && auto_mode)
            |=> o_rdata[2:1] == {$past(ratio_now), 1'b0};
    endproperty
    a_auto_read: assert property (p_auto_read)
        else $error("ratio read-back not the ratio in use");

    property p_auto_only;
        @(posedge i_clk) disable iff (i_sys_rst)
        !auto_mode |-> !deb_run;
    endproperty
    a_auto_only: assert property (p_auto_only)
        else $error("monitoring outside automatic mode");
endmodule
`default_nettype wire

// ==== tb/cpmc_sink_model.sv ====
// Behavioural model of the current sinks and their low-voltage comparators
`timescale 1ns/1ns
`default_nettype none
module cpmc_sink_model (
    input  wire logic [4:0]          i_low_dem, // Sinks starved of headroom
    input  wire logic [4:0]          i_en_dem,  // Sinks switched on
    input  wire cpmc_pkg::cpmc_pump_t i_pump,   // Pump commands
    output logic [4:0]               o_sink_low, // Comparator flags
    output logic [4:0]               o_sink_on   // Sink enables
);
    import cpmc_pkg::*;
    //==========================================================
    // Comparators
    logic boosted; // Doubled output lifts every sink above threshold

    assign boosted   = i_pump.on & i_pump.ratio_double;
    assign o_sink_on = i_en_dem;
    // A disabled sink draws nothing, so it can never report low
    assign o_sink_low = i_low_dem & i_en_dem & ~{5{boosted}};
endmodule
`default_nettype wire

// ==== tb/cpmc_tb_top.sv ====
// Self-checking testbench of the pump mode control
`timescale 1ns/1ns
`default_nettype none
module cpmc_tb_top;
    import cpmc_pkg::*;
    //==========================================================
    // Signals
    localparam int SHORT = 20;         // Shortened normal debounce
    localparam int LONG  = 50;         // Shortened first debounce
    logic       i_clk     = 1'b0;      // 125 MHz clock
    logic       i_sys_rst = 1'b1;      // Held through start
    cpmc_bus_t  i_bus     = '0;        // Register port
    logic [7:0] o_rdata;               // Read data
    logic [4:0] sink_low;              // Model comparator flags
    logic [4:0] sink_on;               // Model sink enables
    logic [4:0] low_dem   = 5'h00;     // Starved sinks
    logic [4:0] en_dem    = 5'h00;     // Enabled sinks
    cpmc_pump_t o_pump;                // Pump commands
    logic       o_onkey_pulldown_en;   // Key pulldown
    logic       rd_pend   = 1'b0;      // Read data due this cycle
    logic [7:0] exp_q[$];              // Expected read data
    int         mismatches = 0;
    int         cmp_count  = 0;

    always #4 i_clk = ~i_clk;

    cpmc_top #(.SHORT_CYC(SHORT), .LONG_CYC(LONG)) cpmc_top_inst (
        .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_bus(i_bus),
        .o_rdata(o_rdata), .i_sink_low(sink_low), .i_sink_on(sink_on),
        .o_pump(o_pump), .o_onkey_pulldown_en(o_onkey_pulldown_en));

    cpmc_sink_model cpmc_sink_model_inst (
        .i_low_dem(low_dem), .i_en_dem(en_dem), .i_pump(o_pump),
        .o_sink_low(sink_low), .o_sink_on(sink_on));

    //==========================================================
    // Compare and report
    task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cmp_bit(input logic got, input logic exp);
        cmp_byte({7'h00, got}, {7'h00, exp});
    endtask

    task automatic finish_test;
        $display("Comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // A wait that runs out of its bound ends the run as a failure
    task automatic give_up;
        mismatches++;
        finish_test();
    endtask

    //==========================================================
    // Bus master, one strobe cycle then a quiet cycle
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge i_clk);
        i_bus <= '0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge i_clk);
        i_bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        exp_q.push_back(e);
        @(posedge i_clk);
        i_bus <= '0;
    endtask

    // Read data stands only in the cycle after the strobe, else zero
    always @(posedge i_clk) begin
        rd_pend <= i_bus.rd;
    end

    always @(negedge i_clk) begin
        if (rd_pend) begin
            cmp_byte(o_rdata, exp_q.size() > 0 ? exp_q.pop_front() : 8'hxx);
        end else if (!i_sys_rst) begin
            cmp_byte(o_rdata, 8'h00);
        end
    end

    //==========================================================
    // Pump observation helpers, sampled mid-cycle; the check hands
    // back on a rising edge so that later stimulus changes there
    task automatic chk_pump(input logic on, input logic dbl);
        @(negedge i_clk);
        cmp_bit(o_pump.on, on);
        cmp_bit(o_pump.ratio_double, dbl);
        @(posedge i_clk);
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge i_clk);
    endtask

    // Bounded wait for the switch-up, looked at mid-cycle only
    task automatic wait_dbl(input int lim);
        int n = 0;
        do begin
            @(negedge i_clk);
            n++;
        end while (o_pump.ratio_double !== 1'b1 && n < lim);
        if (o_pump.ratio_double !== 1'b1) begin
            give_up();
        end
    endtask

    // Spacing between two pump clock pulses
    task automatic measure(input int exp_cyc);
        int n = 0;
        @(negedge i_clk);
        while (o_pump.clk_en !== 1'b1 && n < 300) begin
            @(negedge i_clk);
            n++;
        end
        if (o_pump.clk_en !== 1'b1) begin
            give_up();
        end
        n = 0;
        do begin
            @(negedge i_clk);
            n++;
        end while (o_pump.clk_en !== 1'b1 && n < 300);
        if (o_pump.clk_en !== 1'b1) begin
            give_up();
        end
        cmp_byte(n[7:0], exp_cyc[7:0]);
    endtask

    //==========================================================
    // Main sequence
    initial begin
        logic [7:0] v;
        void'($urandom(30));
        repeat (8) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        en_dem    <= 5'h1f;
        // Reset values, unmapped and read-only places
        rd(ADDR_CTRL, CTRL_RST);
        rd(ADDR_LINK, 8'h00);
        rd(8'h55, 8'h00);
        wr(ADDR_STATUS, 8'h1f);
        rd(ADDR_STATUS, 8'h00);
        chk_pump(1'b0, 1'b0);
        cmp_bit(o_onkey_pulldown_en, 1'b1);
        // Self-start from a linked starved sink
        wr(ADDR_LINK, 8'h04);
        low_dem <= 5'h04;
        idle(2);
        chk_pump(1'b1, 1'b0);
        wr(ADDR_CTRL, 8'h00);
        chk_pump(1'b0, 1'b0);
        low_dem <= 5'h00;
        // Automatic switching, links set before the pump starts
        wr(ADDR_LINK, 8'h01);
        wr(ADDR_CTRL, 8'h01);
        chk_pump(1'b1, 1'b0);
        low_dem <= 5'h02;
        idle(40);
        chk_pump(1'b1, 1'b0);
        low_dem <= 5'h01;
        idle(15);
        low_dem <= 5'h00;
        idle(2);
        low_dem <= 5'h01;
        idle(15);
        chk_pump(1'b1, 1'b0);
        wait_dbl(12);
        chk_pump(1'b1, 1'b1);
        rd(ADDR_CTRL, 8'h05);
        rd(ADDR_STATUS, 8'h00);
        low_dem <= 5'h00;
        idle(30);
        chk_pump(1'b1, 1'b1);
        // Long first debounce after a restart
        wr(ADDR_CTRL, 8'h00);
        chk_pump(1'b0, 1'b0);
        wr(ADDR_CTRL, 8'h41);
        low_dem <= 5'h01;
        idle(30);
        chk_pump(1'b1, 1'b0);
        wait_dbl(30);
        chk_pump(1'b1, 1'b1);
        // Manual ratio, every field code, sink kept starved
        wr(ADDR_CTRL, 8'h00);
        for (int r = 0; r < 4; r++) begin
            wr(ADDR_CTRL, {4'h0, 1'b1, r[1:0], 1'b1});
            idle(25);
            chk_pump(1'b1, r[1]);
            rd(ADDR_CTRL, {4'h0, 1'b1, r[1:0], 1'b1});
        end
        low_dem <= 5'h00;
        // Pump clock rates
        wr(ADDR_CTRL, 8'h01);
        measure(FAST_PUMP_CYC);
        wr(ADDR_CTRL, 8'h11);
        measure(SLOW_PUMP_CYC);
        // Key pulldown control
        wr(ADDR_CTRL, 8'h20);
        chk_pump(1'b0, 1'b0);
        cmp_bit(o_onkey_pulldown_en, 1'b0);
        wr(ADDR_CTRL, 8'h00);
        chk_pump(1'b0, 1'b0);
        cmp_bit(o_onkey_pulldown_en, 1'b1);
        // Random link patterns and live status flags, pump off
        repeat (8) begin
            v = 8'($urandom);
            low_dem <= v[4:0];
            wr(ADDR_LINK, v);
            rd(ADDR_LINK, {3'h0, v[4:0]});
            rd(ADDR_STATUS, {3'h0, v[4:0]});
        end
        idle(2);
        finish_test();
    end

    // Hang guard
    initial begin
        repeat (100000) @(posedge i_clk);
        mismatches++;
        finish_test();
    end
endmodule
`default_nettype wire
